// *** core/port_d_pin_mux.sv ***
// What this block does
// - upper gpio pin: direction bit 1 drives, 0 inputs
// - lower gpio pin: direction bit 1 drives, 0 inputs
// - upper direction register maps pins 31..16
// - lower direction register maps pins 15..0
// - upper direction bit ignored unless pin is gpio
// - lower direction bit ignored unless pin is gpio
// - direction registers clear only on power-on reset
// - control registers clear only on power-on reset
// - small package: registers accessible, upper pins untouched
// - two-bit fields; select a 31..24, b 23..16
// - operating mode overrides stored field selections
// - pin 31: gpio, bus bit, conversion trigger
// - pin 30: gpio, bus bit, interrupt acknowledge
// - pin 29: gpio, bus bit, chip select 3
// - single chip drops bus; wide bus forces bus
// - pin 28: gpio, bus bit, chip select 2
// - pins 27..24: dma acknowledge and request functions
//
// Added by the designer: the register offsets and the strobed register port.
`default_nettype none
module port_d_pin_mux #(
   parameter bit HAS_UPPER_PINS = 1'b1,
   parameter int REG_W = port_d_pkg::REG_W
) (
   // clock and power-on reset
   input wire logic core_clk,
   input wire logic rstn,
   // register port
   input wire port_d_pkg::reg_req_t reg_req,
   output logic [port_d_pkg::REG_W-1:0] rd_data,
   // operating mode straps, asynchronous
   input wire logic mode_single_chip,
   input wire logic mode_wide_bus,
   // pads
   input wire logic [port_d_pkg::PIN_N-1:0] pad_in,
   output port_d_pkg::pad_drive_t pad_drive,
   // port data logic
   input wire logic [port_d_pkg::PIN_N-1:0] gpio_out,
   output logic [port_d_pkg::PIN_N-1:0] gpio_in,
   // external data bus
   input wire logic [port_d_pkg::PIN_N-1:0] data_bus_out,
   input wire logic data_bus_oe,
   output logic [port_d_pkg::PIN_N-1:0] data_bus_in,
   // lower pin functions chosen elsewhere
   input wire logic [port_d_pkg::REG_W-1:0] lower_is_gpio,
   input wire logic [port_d_pkg::REG_W-1:0] lower_alt_out,
   input wire logic [port_d_pkg::REG_W-1:0] lower_alt_oe,
   // peripherals
   input wire port_d_pkg::periph_out_t periph_out,
   output port_d_pkg::periph_in_t periph_in
);

   if (REG_W != port_d_pkg::REG_W)
   begin : g_check
      $error("port_d_pin_mux serves only 16-bit registers");
   end

   // registers; rstn is the external power-on reset only, so manual and
   // watchdog resets, standby and sleep leave them untouched
   logic [15:0] port_d_upper_direction;
   logic [15:0] port_d_lower_direction;
   logic [15:0] port_d_upper_function_select_a;
   logic [15:0] port_d_upper_function_select_b;

   // synchronisers
   logic [port_d_pkg::PIN_N-1:0] pad_meta;
   logic [port_d_pkg::PIN_N-1:0] pad_sync;
   logic [1:0] mode_meta;
   logic [1:0] mode_sync;
   logic single_chip;
   logic wide_bus;

   // decode
   logic wr_upper_dir;
   logic wr_lower_dir;
   logic wr_sel_a;
   logic wr_sel_b;
   logic [15:0] next_rd_data;
   port_d_pkg::pin_role_t role [port_d_pkg::PIN_N];
   logic [7:0] periph_vec;
   port_d_pkg::pad_drive_t next_pad_drive;
   logic [port_d_pkg::PIN_N-1:0] next_data_bus_in;
   port_d_pkg::periph_in_t next_periph_in;

   // reserved code falls back to gpio, so nothing undefined is driven
   function automatic port_d_pkg::pin_role_t resolve(
      input logic [1:0] code,
      input logic sc,
      input logic wide,
      input logic sc_ok,
      input logic has_periph
   );
      port_d_pkg::pin_role_t r;
      r = port_d_pkg::ROLE_GPIO;
      if (wide)
      begin
         r = port_d_pkg::ROLE_BUS;
      end
      else
      begin
         case (code)
            port_d_pkg::CODE_GPIO: r = port_d_pkg::ROLE_GPIO;
            port_d_pkg::CODE_BUS: r = sc ? port_d_pkg::ROLE_GPIO : port_d_pkg::ROLE_BUS;
            port_d_pkg::CODE_PERIPH:
               r = (has_periph && (!sc || sc_ok)) ? port_d_pkg::ROLE_PERIPH
                   : port_d_pkg::ROLE_GPIO;
            default: r = port_d_pkg::ROLE_GPIO;
         endcase
      end
      return r;
   endfunction

   assign single_chip = mode_sync[0];
   assign wide_bus = mode_sync[1] & ~mode_sync[0];

   assign wr_upper_dir = reg_req.write && (reg_req.addr == port_d_pkg::ADDR_UPPER_DIR);
   assign wr_lower_dir = reg_req.write && (reg_req.addr == port_d_pkg::ADDR_LOWER_DIR);
   assign wr_sel_a = reg_req.write && (reg_req.addr == port_d_pkg::ADDR_SEL_A);
   assign wr_sel_b = reg_req.write && (reg_req.addr == port_d_pkg::ADDR_SEL_B);

   assign next_rd_data = !reg_req.read ? 16'h0000 :
      (reg_req.addr == port_d_pkg::ADDR_UPPER_DIR) ? port_d_upper_direction :
      (reg_req.addr == port_d_pkg::ADDR_LOWER_DIR) ? port_d_lower_direction :
      (reg_req.addr == port_d_pkg::ADDR_SEL_A) ? port_d_upper_function_select_a :
      port_d_upper_function_select_b;

   // peripheral output sources for pins 31..24
   assign periph_vec = {1'b0, periph_out.irq_ack, periph_out.cs3_n, periph_out.cs2_n,
      periph_out.dma_ack_ch1, periph_out.dma_ack_ch0, 2'h0};

   // lower pins: direction only counts while the pin is gpio
   for (genvar i = 0; i < 16; i++)
   begin : g_lower
      assign role[i] = lower_is_gpio[i] ? port_d_pkg::ROLE_GPIO : port_d_pkg::ROLE_PERIPH;
      assign next_pad_drive.oe[i] = lower_is_gpio[i] ? port_d_lower_direction[i]
                                    : lower_alt_oe[i];
      assign next_pad_drive.out[i] = lower_is_gpio[i] ? gpio_out[i] : lower_alt_out[i];
      assign next_data_bus_in[i] = 1'b0;
   end

   // pins 23..16: no peripheral function here, so code 10 falls back to gpio
   for (genvar i = 16; i < 24; i++)
   begin : g_mid
      assign role[i] = resolve(port_d_upper_function_select_b[2*(i-16) +: 2],
         single_chip, wide_bus, 1'b0, 1'b0);
   end

   // pins 31..24 follow select a
   for (genvar i = 24; i < 32; i++)
   begin : g_high
      assign role[i] = resolve(port_d_upper_function_select_a[2*(i-24) +: 2],
         single_chip, wide_bus, port_d_pkg::SC_PERIPH_OK[i-24], 1'b1);
   end

   for (genvar i = 16; i < 32; i++)
   begin : g_upper
      logic oe_sel;
      logic out_sel;
      always_comb
      begin
         oe_sel = 1'b0;
         out_sel = 1'b0;
         case (role[i])
            port_d_pkg::ROLE_GPIO:
            begin
               oe_sel = port_d_upper_direction[i-16];
               out_sel = gpio_out[i];
            end
            port_d_pkg::ROLE_BUS:
            begin
               oe_sel = data_bus_oe;
               out_sel = data_bus_out[i];
            end
            port_d_pkg::ROLE_PERIPH:
            begin
               if (i >= 24)
               begin
                  oe_sel = port_d_pkg::PERIPH_IS_OUT[(i >= 24) ? i-24 : 0];
                  out_sel = periph_vec[(i >= 24) ? i-24 : 0];
               end
            end
            default:
            begin
               oe_sel = 1'b0;
               out_sel = 1'b0;
            end
         endcase
      end
      // without the upper pins the registers still work but reach no pad
      assign next_pad_drive.oe[i] = HAS_UPPER_PINS & oe_sel;
      assign next_pad_drive.out[i] = HAS_UPPER_PINS & out_sel;
      assign next_data_bus_in[i] = (role[i] == port_d_pkg::ROLE_BUS) & pad_sync[i];
   end

   assign next_periph_in.conv_trig = (role[port_d_pkg::PIN_TRIG] == port_d_pkg::ROLE_PERIPH)
      & pad_sync[port_d_pkg::PIN_TRIG];
   assign next_periph_in.dma_req_ch1 = (role[port_d_pkg::PIN_DMA_REQ_CH1] == port_d_pkg::ROLE_PERIPH)
      & pad_sync[port_d_pkg::PIN_DMA_REQ_CH1];
   assign next_periph_in.dma_req_ch0 = (role[port_d_pkg::PIN_DMA_REQ_CH0] == port_d_pkg::ROLE_PERIPH)
      & pad_sync[port_d_pkg::PIN_DMA_REQ_CH0];

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         port_d_upper_direction <= port_d_pkg::DIR_RESET;
         port_d_lower_direction <= port_d_pkg::DIR_RESET;
      end
      else
      begin
         if (wr_upper_dir)
            port_d_upper_direction <= reg_req.wdata;
         if (wr_lower_dir)
            port_d_lower_direction <= reg_req.wdata;
      end
   end

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         port_d_upper_function_select_a <= port_d_pkg::SEL_RESET;
         port_d_upper_function_select_b <= port_d_pkg::SEL_RESET;
      end
      else
      begin
         if (wr_sel_a)
            port_d_upper_function_select_a <= reg_req.wdata;
         if (wr_sel_b)
            port_d_upper_function_select_b <= reg_req.wdata;
      end
   end

   // pads and straps cross in from outside: two flops before any use
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         pad_meta <= '0;
         pad_sync <= '0;
         mode_meta <= 2'h0;
         mode_sync <= 2'h0;
      end
      else
      begin
         pad_meta <= pad_in;
         pad_sync <= pad_meta;
         mode_meta <= {mode_wide_bus, mode_single_chip};
         mode_sync <= mode_meta;
      end
   end

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rd_data <= 16'h0000;
         pad_drive <= '0;
         gpio_in <= '0;
         data_bus_in <= '0;
         periph_in <= '0;
      end
      else
      begin
         rd_data <= next_rd_data;
         pad_drive <= next_pad_drive;
         gpio_in <= pad_sync;
         data_bus_in <= next_data_bus_in;
         periph_in <= next_periph_in;
      end
   end

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rstn);

   property p_upper_gpio_dir;
      (!wide_bus && port_d_upper_function_select_a[15:14] == 2'h0)
      |=> pad_drive.oe[31] == (HAS_UPPER_PINS & $past(port_d_upper_direction[15]));
   endproperty
   a_upper_gpio_dir: assert property (p_upper_gpio_dir) else $error("pin31 oe not dir");

   property p_lower_gpio_dir;
      lower_is_gpio[0] |=> pad_drive.oe[0] == $past(port_d_lower_direction[0]);
   endproperty
   a_lower_gpio_dir: assert property (p_lower_gpio_dir) else $error("pin0 oe not dir");

   property p_upper_write_read;
      (reg_req.write && reg_req.addr == port_d_pkg::ADDR_UPPER_DIR)
      ##1 (reg_req.read && reg_req.addr == port_d_pkg::ADDR_UPPER_DIR && !reg_req.write)
      |=> rd_data == $past(reg_req.wdata, 2);
   endproperty
   a_upper_write_read: assert property (p_upper_write_read) else $error("upper dir readback");

   property p_lower_write;
      (reg_req.write && reg_req.addr == port_d_pkg::ADDR_LOWER_DIR)
      |=> port_d_lower_direction == $past(reg_req.wdata);
   endproperty
   a_lower_write: assert property (p_lower_write) else $error("lower dir not written");

   property p_dir_ignored;
      (!lower_is_gpio[3]) |=> pad_drive.oe[3] == $past(lower_alt_oe[3]);
   endproperty
   a_dir_ignored: assert property (p_dir_ignored) else $error("lower alt oe not used");

   property p_cs3_select;
      (!single_chip && !wide_bus && port_d_upper_function_select_a[11:10] == 2'h2)
      |=> pad_drive.oe[29] == HAS_UPPER_PINS
          && pad_drive.out[29] == (HAS_UPPER_PINS & $past(periph_out.cs3_n));
   endproperty
   a_cs3_select: assert property (p_cs3_select) else $error("cs3 not on pin29");

   property p_irq_ack_single;
      (single_chip && port_d_upper_function_select_a[13:12] == 2'h2)
      |=> pad_drive.oe[30] == (HAS_UPPER_PINS & $past(port_d_upper_direction[14]));
   endproperty
   a_irq_ack_single: assert property (p_irq_ack_single) else $error("pin30 not gpio");

   property p_trig_in;
      (!wide_bus && port_d_upper_function_select_a[15:14] == 2'h2)
      |=> periph_in.conv_trig == $past(pad_sync[31]);
   endproperty
   a_trig_in: assert property (p_trig_in) else $error("trigger not routed");

   property p_wide_bus;
      wide_bus |=> pad_drive.oe[24] == (HAS_UPPER_PINS & $past(data_bus_oe));
   endproperty
   a_wide_bus: assert property (p_wide_bus) else $error("wide bus not forced");

   property p_small_pkg;
      !HAS_UPPER_PINS |-> pad_drive.oe[31:16] == 16'h0000;
   endproperty
   a_small_pkg: assert property (p_small_pkg) else $error("absent pins driven");

   c_dir_write: cover property (wr_upper_dir ##1 pad_drive.oe[16]);
   c_periph_dreq: cover property (role[24] == port_d_pkg::ROLE_PERIPH ##2 periph_in.dma_req_ch0);
   c_wide: cover property (wide_bus ##1 data_bus_in != '0);
   c_read: cover property (reg_req.read ##1 rd_data != 16'h0000);

endmodule
`default_nettype wire

// *** core/port_d_pkg.sv ***
`default_nettype none
package port_d_pkg;
   localparam int REG_W = 16;
   localparam int ADDR_W = 2;
   localparam int PIN_N = 32;
   localparam int UPPER_BASE = 16;
   localparam int SEL_A_BASE = 24;
   localparam int FIELD_W = 2;
   localparam int SYNC_DEPTH = 2;
   localparam logic [1:0] ADDR_UPPER_DIR = 2'h0;
   localparam logic [1:0] ADDR_LOWER_DIR = 2'h1;
   localparam logic [1:0] ADDR_SEL_A = 2'h2;
   localparam logic [1:0] ADDR_SEL_B = 2'h3;
   localparam logic [15:0] DIR_RESET = 16'h0000;
   localparam logic [15:0] SEL_RESET = 16'h0000;
   // pins 31..24: which peripheral functions survive single-chip mode
   localparam logic [7:0] SC_PERIPH_OK = 8'h80;
   // pins 31..24: peripheral function is an output (else an input)
   localparam logic [7:0] PERIPH_IS_OUT = 8'h7c;
   localparam int PIN_TRIG = 31;
   localparam int PIN_IRQ_ACK = 30;
   localparam int PIN_CS3 = 29;
   localparam int PIN_CS2 = 28;
   localparam int PIN_DMA_REQ_CH1 = 25;
   localparam int PIN_DMA_REQ_CH0 = 24;

   typedef enum logic [1:0] {
      CODE_GPIO = 2'h0,
      CODE_BUS = 2'h1,
      CODE_PERIPH = 2'h2,
      CODE_RSVD = 2'h3
   } pin_code_t;

   typedef enum logic [1:0] {
      ROLE_GPIO = 2'h0,
      ROLE_BUS = 2'h1,
      ROLE_PERIPH = 2'h3
   } pin_role_t;

   typedef struct packed {
      logic write;
      logic read;
      logic [ADDR_W-1:0] addr;
      logic [REG_W-1:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic irq_ack;
      logic cs3_n;
      logic cs2_n;
      logic dma_ack_ch1;
      logic dma_ack_ch0;
   } periph_out_t;

   typedef struct packed {
      logic conv_trig;
      logic dma_req_ch1;
      logic dma_req_ch0;
   } periph_in_t;

   typedef struct packed {
      logic [PIN_N-1:0] out;
      logic [PIN_N-1:0] oe;
   } pad_drive_t;
endpackage
`default_nettype wire

// *** tb/pad_world.sv ***
`default_nettype none
module pad_world
(
   // drive coming out of the port
   input wire port_d_pkg::pad_drive_t pad_drive,
   // level the far devices put on pins the port leaves alone
   input wire logic [port_d_pkg::PIN_N-1:0] ext_level,
   // level seen at the pads
   output logic [port_d_pkg::PIN_N-1:0] pad_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // an enabled pin reads back its own drive, otherwise the far device wins
   assign pad_in = (pad_drive.oe & pad_drive.out) | (~pad_drive.oe & ext_level);
endmodule
`default_nettype wire

// *** tb/port_d_direction_and_function_select_test.sv ***
`default_nettype none
module port_d_direction_and_function_select_test;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [31:0] oe;
      logic [31:0] out;
      logic [31:0] gin;
      logic [31:0] dbin;
      port_d_pkg::periph_in_t pin;
   } snap_t;
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   port_d_pkg::reg_req_t reg_req = '0;
   logic [15:0] rd_data;
   logic mode_single_chip = 1'b0;
   logic mode_wide_bus = 1'b0;
   logic [31:0] pad_in;
   port_d_pkg::pad_drive_t pad_drive;
   logic [31:0] gpio_out = '0;
   logic [31:0] gpio_in;
   logic [31:0] data_bus_out = '0;
   logic data_bus_oe = 1'b0;
   logic [31:0] data_bus_in;
   logic [15:0] lower_is_gpio = '0;
   logic [15:0] lower_alt_out = '0;
   logic [15:0] lower_alt_oe = '0;
   port_d_pkg::periph_out_t periph_out = '0;
   port_d_pkg::periph_in_t periph_in;
   logic [31:0] ext_level = '0;
   // small package copy: registers live, upper pads never driven
   logic [15:0] sm_rd;
   port_d_pkg::pad_drive_t sm_drive;
   logic [15:0] shadow [4] = '{default: 16'h0000};
   logic [15:0] rd_q [$];
   snap_t snap_q [$];
   snap_t exp_s;
   logic rd_seen = 1'b0;
   logic probe = 1'b0;
   int n_mismatch = 0;
   int n_checks = 0;
   int seed = 32'hae33;

   always #2.5 core_clk = ~core_clk;

   port_d_pin_mux #(.HAS_UPPER_PINS(1'b1), .REG_W(port_d_pkg::REG_W)) dut_u (
      .core_clk(core_clk), .rstn(rstn), .reg_req(reg_req), .rd_data(rd_data),
      .mode_single_chip(mode_single_chip), .mode_wide_bus(mode_wide_bus),
      .pad_in(pad_in), .pad_drive(pad_drive), .gpio_out(gpio_out), .gpio_in(gpio_in),
      .data_bus_out(data_bus_out), .data_bus_oe(data_bus_oe), .data_bus_in(data_bus_in),
      .lower_is_gpio(lower_is_gpio), .lower_alt_out(lower_alt_out),
      .lower_alt_oe(lower_alt_oe), .periph_out(periph_out), .periph_in(periph_in)
   );
   pad_world world_u (.pad_drive(pad_drive), .ext_level(ext_level), .pad_in(pad_in));
   port_d_pin_mux #(.HAS_UPPER_PINS(1'b0), .REG_W(port_d_pkg::REG_W)) small_u (
      .core_clk(core_clk), .rstn(rstn), .reg_req(reg_req), .rd_data(sm_rd),
      .mode_single_chip(mode_single_chip), .mode_wide_bus(mode_wide_bus),
      .pad_in(pad_in), .pad_drive(sm_drive), .gpio_out(gpio_out), .gpio_in(),
      .data_bus_out(data_bus_out), .data_bus_oe(data_bus_oe), .data_bus_in(),
      .lower_is_gpio(lower_is_gpio), .lower_alt_out(lower_alt_out),
      .lower_alt_oe(lower_alt_oe), .periph_out(periph_out), .periph_in()
   );

   task automatic bad(input string m);
      n_mismatch++;
      $display("ERROR at %0t: %s", $time, m);
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // strobes stay up until the next call, so calls run back to back
   task automatic bus(input logic w, input logic r, input logic [1:0] a, input logic [15:0] d);
      @(posedge core_clk);
      reg_req <= '{write: w, read: r, addr: a, wdata: d};
   endtask

   task automatic wr(input logic [1:0] a, input logic [15:0] d);
      bus(1'b1, 1'b0, a, d);
      shadow[a] = d;
   endtask

   task automatic rd(input logic [1:0] a);
      bus(1'b0, 1'b1, a, 16'h0000);
      rd_q.push_back(shadow[a]);
   endtask

   task automatic shake();
      logic [31:0] r [5];
      foreach (r[k]) r[k] = $random(seed);
      @(posedge core_clk);
      gpio_out <= r[0];
      data_bus_out <= r[1];
      ext_level <= r[2];
      lower_is_gpio <= r[3][15:0];
      lower_alt_out <= r[3][31:16];
      lower_alt_oe <= r[4][15:0];
      data_bus_oe <= r[4][16];
      periph_out <= r[4][21:17];
   endtask

   function automatic snap_t predict();
      snap_t s;
      logic [31:0] sel;
      logic [31:0] p;
      logic [31:0] r2;
      logic [7:0] pvec;
      logic [1:0] c;
      logic wide;
      logic o;
      logic e;
      int role;
      s = '0;
      r2 = '0;
      sel = {shadow[port_d_pkg::ADDR_SEL_A], shadow[port_d_pkg::ADDR_SEL_B]};
      pvec = {1'b0, periph_out, 2'b00};
      wide = mode_wide_bus & ~mode_single_chip;
      for (int i = 0; i < 32; i++)
      begin
         role = lower_is_gpio[i] ? 0 : 3;
         if (i >= 16)
         begin
            c = sel[2*(i-16) +: 2];
            if (wide || (c == 2'h1 && !mode_single_chip))
               role = 1;
            else if (c == 2'h2 && i >= 24 && (!mode_single_chip || i == 31))
               role = 2;
            else
               role = 0;
         end
         o = (role == 0) ? gpio_out[i] : (role == 1) ? data_bus_out[i] :
             (role == 2) ? pvec[i-24] : lower_alt_out[i];
         e = (role == 0) ? ((i < 16) ? shadow[1][i] : shadow[0][i-16]) :
             (role == 1) ? data_bus_oe :
             (role == 2) ? port_d_pkg::PERIPH_IS_OUT[i-24] : lower_alt_oe[i];
         p[i] = e ? o : ext_level[i];
         r2[i] = (role == 2);
         s.oe[i] = e;
         s.out[i] = e & o;
         s.dbin[i] = (role == 1) & p[i];
      end
      s.gin = p;
      s.pin = {r2[31] & p[31], r2[25] & p[25], r2[24] & p[24]};
      return s;
   endfunction

   // enough edges for strap sync, pad drive and pad input sync to land
   task automatic check_pads();
      repeat (8) @(posedge core_clk);
      snap_q.push_back(predict());
      probe <= 1'b1;
      @(posedge core_clk);
      probe <= 1'b0;
   endtask

   always @(posedge core_clk) rd_seen <= reg_req.read;

   always @(negedge core_clk)
   begin
      n_checks++;
      if (rd_seen && rd_data !== rd_q.pop_front())
         bad("read data differs");
      if (!rd_seen && rd_data !== 16'h0000)
         bad("read data outside its cycle");
      if (sm_rd !== rd_data)
         bad("small package read data");
      if (probe)
      begin
         exp_s = snap_q.pop_front();
         n_checks += 6;
         if (pad_drive.oe !== exp_s.oe)
            bad("pad enable");
         if (sm_drive.oe !== {16'h0000, exp_s.oe[15:0]})
            bad("small package pad enable");
         if ((pad_drive.out & pad_drive.oe) !== exp_s.out)
            bad("pad output");
         if (gpio_in !== exp_s.gin)
            bad("port input");
         if (data_bus_in !== exp_s.dbin)
            bad("bus input");
         if (periph_in !== exp_s.pin)
            bad("peripheral input");
      end
   end

   initial
   begin
      logic [15:0] w;
      logic [1:0] m;
      repeat (4) @(posedge core_clk);
      rstn <= 1'b1;
      for (int a = 0; a < 4; a++) rd(2'(a));
      bus(1'b0, 1'b0, 2'h0, 16'h0000);
      check_pads();
      for (int a = 0; a < 4; a++)
      begin
         wr(2'(a), 16'($random(seed)));
         rd(2'(a));
      end
      // drop the last read strobe so it stands one cycle only
      bus(1'b0, 1'b0, 2'h0, 16'h0000);
      // every code in every mode, then random mixes; code 11 sent on purpose
      for (int it = 0; it < 24; it++)
      begin
         w = (it < 16) ? {8{2'(it % 4)}} : 16'($random(seed));
         m = 2'((it < 16) ? it / 4 : it % 4);
         shake();
         mode_single_chip <= m[0];
         mode_wide_bus <= m[1];
         wr(port_d_pkg::ADDR_SEL_A, w);
         wr(port_d_pkg::ADDR_SEL_B, {w[7:0], w[15:8]});
         wr(port_d_pkg::ADDR_UPPER_DIR, 16'($random(seed)));
         wr(port_d_pkg::ADDR_LOWER_DIR, 16'($random(seed)));
         bus(1'b0, 1'b0, 2'h0, 16'h0000);
         check_pads();
      end
      // a second power-on reset clears all four registers
      @(posedge core_clk);
      rstn <= 1'b0;
      repeat (2) @(posedge core_clk);
      rstn <= 1'b1;
      shadow = '{default: 16'h0000};
      for (int a = 0; a < 4; a++) rd(2'(a));
      bus(1'b0, 1'b0, 2'h0, 16'h0000);
      check_pads();
      results();
   end

   initial
   begin
      #20000;
      n_mismatch++;
      results();
   end
endmodule
`default_nettype wire
